// >>> design/phys_filter_pkg.sv
// Constants shared by the physical request filter low design
package phys_filter_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam logic [APB_AW-1:0] OFS_NODE_EN_LOW_SET = 12'h108;
	localparam logic [APB_AW-1:0] OFS_NODE_EN_LOW_CLEAR = 12'h11C;
	localparam logic [APB_AW-1:0] OFS_ROUTE_COUNT = 12'h0F8;
	localparam logic [APB_AW-1:0] OFS_ROUTE_LAST = 12'h0FC;
	localparam logic [1:0] WORD_ALIGN = 2'h0;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int NODE_LOW_COUNT = 32;
	localparam int NODE_ID_W = 6;
	localparam int NODE_LOW_W = 5;
	localparam logic [NODE_LOW_COUNT-1:0] NODE_EN_RESET = 32'h00000000;
	localparam int COUNT_HALF = 16;
	localparam int LAST_NODE_LSB = 0;
	localparam int LAST_PHYS_BIT = 8;
	localparam int LAST_ASYNC_BIT = 9;
	localparam int LAST_REJECT_BIT = 10;
	localparam int BYTE_W = 8;
	localparam int STRB_W = 4;

endpackage : phys_filter_pkg

// >>> design/node_bit_pick.sv
// Selects one per-node enable bit from a vector by node index
`timescale 1ns/10ps
`default_nettype none

module node_bit_pick #(
	parameter int WIDTH = 32
) (
	// Enable vector
	input wire logic [WIDTH-1:0] vec,
	// Node index within the vector
	input wire logic [$clog2(WIDTH)-1:0] index,
	// Selected bit
	output logic picked
);

	initial begin
		if (WIDTH < 2 || (WIDTH & (WIDTH - 1)) != 0) begin
			$error("node_bit_pick: WIDTH must be a power of two, at least 2");
		end
	end

	assign picked = vec[index];

endmodule : node_bit_pick

`default_nettype wire

// >>> design/physical_request_filter_low.sv
// Physical request filter for low node IDs with APB set/clear access
// Functional notes
// - Hold 32 enable bits; bit n enables physical handling for node n.
// - Physical-bound requests passing the async filter are checked again here.
// - Enable bit clear: route the request to the asynchronous request context.
// - Enable bit set: serve the request through the physical request context.
// - Set and clear addresses; both read the vector; it resets to zero.
// - Nodes 32 and above use the companion high vector, not this one.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module physical_request_filter_low
	import phys_filter_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [APB_DW-1:0] pwdata,
	input wire logic [STRB_W-1:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [APB_DW-1:0] prdata,
	// Receive path request
	input wire logic reqValid,
	input wire logic reqPhysTarget,
	input wire logic reqAsyncPass,
	input wire logic [NODE_ID_W-1:0] reqSrcNode,
	// Companion high filter vector
	input wire logic [NODE_LOW_COUNT-1:0] highEnable,
	// Routing decision
	output logic physGo,
	output logic asyncGo,
	output logic rejectGo,
	output logic [NODE_ID_W-1:0] routeNode,
	// Current enable vector
	output logic [NODE_LOW_COUNT-1:0] nodeEnable
);

	initial begin
		if (COUNT_W < 1 || COUNT_W > COUNT_HALF) begin
			$error("physical_request_filter_low: COUNT_W must be 1 to 16");
		end
	end

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic setup;
	logic access;
	logic hitSet;
	logic hitClear;
	logic hitCount;
	logic hitLast;
	logic mapped;
	logic wrDo;
	logic [APB_DW-1:0] strbMask;
	logic [APB_DW-1:0] wrOnes;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hitSet = (paddr == OFS_NODE_EN_LOW_SET);
	assign hitClear = (paddr == OFS_NODE_EN_LOW_CLEAR);
	assign hitCount = (paddr == OFS_ROUTE_COUNT);
	assign hitLast = (paddr == OFS_ROUTE_LAST);
	assign mapped = (hitSet || hitClear || hitCount || hitLast) && (paddr[1:0] == WORD_ALIGN);
	// Zero wait states; read data is prepared in the setup cycle
	assign pready = 1'b1;
	assign pslverr = access && (!mapped || (pwrite && (hitCount || hitLast)));
	assign wrDo = access && pwrite && pready && mapped;

	always_comb begin
		strbMask = '0;
		for (int b = 0; b < STRB_W; b++) begin
			strbMask[b*BYTE_W +: BYTE_W] = {BYTE_W{pstrb[b]}};
		end
	end

	assign wrOnes = pwdata & strbMask;

	// ----------------------------------------------------------------
	// Enable vector
	// ----------------------------------------------------------------
	logic [NODE_LOW_COUNT-1:0] nodeEn_r;
	logic [NODE_LOW_COUNT-1:0] nodeEn_nxt;

	always_comb begin
		nodeEn_nxt = nodeEn_r;
		if (wrDo && hitSet) begin
			nodeEn_nxt = nodeEn_r | wrOnes;
		end else if (wrDo && hitClear) begin
			nodeEn_nxt = nodeEn_r & ~wrOnes;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			nodeEn_r <= NODE_EN_RESET;
		end else begin
			nodeEn_r <= nodeEn_nxt;
		end
	end

	assign nodeEnable = nodeEn_r;

	// ----------------------------------------------------------------
	// Second node comparison
	// ----------------------------------------------------------------
	logic lowBit;
	logic highBit;
	logic isHighNode;
	logic nodeAllowed;

	node_bit_pick #(
		.WIDTH(NODE_LOW_COUNT)
	) u_pick_low (
		.vec(nodeEn_r),
		.index(reqSrcNode[NODE_LOW_W-1:0]),
		.picked(lowBit)
	);

	node_bit_pick #(
		.WIDTH(NODE_LOW_COUNT)
	) u_pick_high (
		.vec(highEnable),
		.index(reqSrcNode[NODE_LOW_W-1:0]),
		.picked(highBit)
	);

	assign isHighNode = reqSrcNode[NODE_ID_W-1];
	assign nodeAllowed = isHighNode ? highBit : lowBit;

	// ----------------------------------------------------------------
	// Routing decision
	// ----------------------------------------------------------------
	logic physGo_r;
	logic asyncGo_r;
	logic rejectGo_r;
	logic [NODE_ID_W-1:0] routeNode_r;
	logic physGo_nxt;
	logic asyncGo_nxt;
	logic rejectGo_nxt;
	logic [NODE_ID_W-1:0] routeNode_nxt;

	always_comb begin
		physGo_nxt = 1'b0;
		asyncGo_nxt = 1'b0;
		rejectGo_nxt = 1'b0;
		routeNode_nxt = routeNode_r;
		if (reqValid) begin
			routeNode_nxt = reqSrcNode;
			if (!reqPhysTarget) begin
				asyncGo_nxt = 1'b1;
			end else if (!reqAsyncPass) begin
				rejectGo_nxt = 1'b1;
			end else if (nodeAllowed) begin
				physGo_nxt = 1'b1;
			end else begin
				asyncGo_nxt = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			physGo_r <= 1'b0;
			asyncGo_r <= 1'b0;
			rejectGo_r <= 1'b0;
			routeNode_r <= '0;
		end else begin
			physGo_r <= physGo_nxt;
			asyncGo_r <= asyncGo_nxt;
			rejectGo_r <= rejectGo_nxt;
			routeNode_r <= routeNode_nxt;
		end
	end

	assign physGo = physGo_r;
	assign asyncGo = asyncGo_r;
	assign rejectGo = rejectGo_r;
	assign routeNode = routeNode_r;

	// ----------------------------------------------------------------
	// Route counters
	// ----------------------------------------------------------------
	logic [COUNT_W-1:0] physCount_r;
	logic [COUNT_W-1:0] asyncCount_r;
	logic [COUNT_W-1:0] physCount_nxt;
	logic [COUNT_W-1:0] asyncCount_nxt;

	always_comb begin
		physCount_nxt = physCount_r;
		asyncCount_nxt = asyncCount_r;
		if (physGo_r) begin
			physCount_nxt = physCount_r + COUNT_W'(1);
		end
		if (asyncGo_r) begin
			asyncCount_nxt = asyncCount_r + COUNT_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			physCount_r <= '0;
			asyncCount_r <= '0;
		end else begin
			physCount_r <= physCount_nxt;
			asyncCount_r <= asyncCount_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [APB_DW-1:0] prdata_r;
	logic [APB_DW-1:0] prdata_nxt;

	always_comb begin
		prdata_nxt = prdata_r;
		if (setup && !pwrite) begin
			prdata_nxt = '0;
			if (hitSet || hitClear) begin
				prdata_nxt = nodeEn_r;
			end else if (hitCount) begin
				prdata_nxt[COUNT_W-1:0] = physCount_r;
				prdata_nxt[COUNT_HALF +: COUNT_W] = asyncCount_r;
			end else if (hitLast) begin
				prdata_nxt[LAST_NODE_LSB +: NODE_ID_W] = routeNode_r;
				prdata_nxt[LAST_PHYS_BIT] = physGo_r;
				prdata_nxt[LAST_ASYNC_BIT] = asyncGo_r;
				prdata_nxt[LAST_REJECT_BIT] = rejectGo_r;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prdata_r <= '0;
		end else begin
			prdata_r <= prdata_nxt;
		end
	end

	assign prdata = prdata_r;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [NODE_LOW_COUNT-1:0] wrOnesSeen;
	logic lowBitSeen;
	logic highBitSeen;

	assign wrOnesSeen = wrOnes;
	assign lowBitSeen = nodeEn_r[reqSrcNode[NODE_LOW_W-1:0]];
	assign highBitSeen = highEnable[reqSrcNode[NODE_LOW_W-1:0]];

	property p_reset_zero;
		@(posedge clk) srst |=> (nodeEn_r == NODE_EN_RESET) && !physGo_r && !asyncGo_r;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("vector not zero after reset");

	property p_set_ones;
		@(posedge clk) disable iff (srst)
		(wrDo && hitSet) |=> nodeEn_r == ($past(nodeEn_r) | $past(wrOnesSeen));
	endproperty
	a_set_ones: assert property (p_set_ones) else $error("set write did not or in ones");

	property p_clear_ones;
		@(posedge clk) disable iff (srst)
		(wrDo && hitClear) |=> nodeEn_r == ($past(nodeEn_r) & ~$past(wrOnesSeen));
	endproperty
	a_clear_ones: assert property (p_clear_ones) else $error("clear write did not drop ones");

	property p_hold_vector;
		@(posedge clk) disable iff (srst)
		!(wrDo && (hitSet || hitClear)) |=> $stable(nodeEn_r);
	endproperty
	a_hold_vector: assert property (p_hold_vector) else $error("vector changed without write");

	property p_read_back;
		@(posedge clk) disable iff (srst)
		(setup && !pwrite && (hitSet || hitClear)) ##1 (access && pready)
		|-> prdata == $past(nodeEn_r);
	endproperty
	a_read_back: assert property (p_read_back) else $error("read did not return vector");

	property p_phys_route;
		@(posedge clk) disable iff (srst)
		(reqValid && reqPhysTarget && reqAsyncPass && !isHighNode && lowBitSeen)
		|=> physGo_r && !asyncGo_r && (routeNode_r == $past(reqSrcNode));
	endproperty
	a_phys_route: assert property (p_phys_route) else $error("enabled node not sent physical");

	property p_async_route;
		@(posedge clk) disable iff (srst)
		(reqValid && reqPhysTarget && reqAsyncPass && !isHighNode && !lowBitSeen)
		|=> asyncGo_r && !physGo_r;
	endproperty
	a_async_route: assert property (p_async_route) else $error("disabled node not sent async");

	property p_high_route;
		@(posedge clk) disable iff (srst)
		(reqValid && reqPhysTarget && reqAsyncPass && isHighNode)
		|=> physGo_r == $past(highBitSeen);
	endproperty
	a_high_route: assert property (p_high_route) else $error("high node used low vector");

	property p_only_checked;
		@(posedge clk) disable iff (srst)
		(!reqValid || (reqPhysTarget && !reqAsyncPass)) |=> !physGo_r;
	endproperty
	a_only_checked: assert property (p_only_checked) else $error("unchecked request sent physical");

	property p_one_route;
		@(posedge clk) disable iff (srst)
		reqValid |=> $onehot({physGo_r, asyncGo_r, rejectGo_r});
	endproperty
	a_one_route: assert property (p_one_route) else $error("request not routed exactly once");

endmodule : physical_request_filter_low

`default_nettype wire

// >>> test/physical_request_filter_low_bench.sv
// Self-checking bench for the physical request filter low block
`timescale 1ns/10ps
`default_nettype none

module physical_request_filter_low_bench
	import phys_filter_pkg::*;
;
	logic clk, srst, psel, penable, pwrite, pready, pslverr, err;
	logic reqValid, reqPhysTarget, reqAsyncPass, physGo, asyncGo, rejectGo;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata, rd;
	logic [STRB_W-1:0] pstrb;
	logic [NODE_ID_W-1:0] reqSrcNode, routeNode;
	logic [NODE_LOW_COUNT-1:0] highEnable, nodeEnable, vec;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	physical_request_filter_low #(.COUNT_W(16)) dut (.clk(clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .reqValid(reqValid),
		.reqPhysTarget(reqPhysTarget), .reqAsyncPass(reqAsyncPass), .reqSrcNode(reqSrcNode),
		.highEnable(highEnable), .physGo(physGo), .asyncGo(asyncGo), .rejectGo(rejectGo),
		.routeNode(routeNode), .nodeEnable(nodeEnable));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task end_sim;
		$display("errors %0d comparisons %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// One APB transfer; read data and error taken at the completing edge
	task apb(input logic wr, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
		input logic [STRB_W-1:0] s);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		// Only the bench timeout ends a stuck access phase
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// One request; route code is {physGo, asyncGo, rejectGo}
	task req(input logic [NODE_ID_W-1:0] node, input logic pt, input logic ap,
		input logic [2:0] exp);
		@(posedge clk);
		reqValid <= 1'b1;
		reqPhysTarget <= pt;
		reqAsyncPass <= ap;
		reqSrcNode <= node;
		@(posedge clk);
		reqValid <= 1'b0;
		#1;
		check(32'({physGo, asyncGo, rejectGo}), 32'(exp), "route");
		check(32'(routeNode), 32'(node), "route node");
	endtask : req

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		apb(1'b0, OFS_NODE_EN_LOW_SET, 32'h0, 4'hF);
		check(rd, 32'h0, "reset via set address");
		apb(1'b0, OFS_NODE_EN_LOW_CLEAR, 32'h0, 4'hF);
		check(rd, 32'h0, "reset via clear address");
	endtask : t_reset

	task t_set_clear;
		apb(1'b1, OFS_NODE_EN_LOW_SET, 32'hA5A50F0F, 4'hF);
		check(32'(err), 32'h0, "set write error");
		apb(1'b1, OFS_NODE_EN_LOW_SET, 32'h0, 4'hF);
		apb(1'b0, OFS_NODE_EN_LOW_SET, 32'h0, 4'hF);
		check(rd, 32'hA5A50F0F, "zeros to set");
		apb(1'b1, OFS_NODE_EN_LOW_CLEAR, 32'h0000000F, 4'hF);
		apb(1'b1, OFS_NODE_EN_LOW_CLEAR, 32'h0, 4'hF);
		apb(1'b0, OFS_NODE_EN_LOW_CLEAR, 32'h0, 4'hF);
		check(rd, 32'hA5A50F00, "clear readback");
		apb(1'b1, OFS_NODE_EN_LOW_SET, 32'hFFFFFFFF, 4'h2);
		apb(1'b0, OFS_NODE_EN_LOW_SET, 32'h0, 4'hF);
		check(rd, 32'hA5A5FF00, "strobed set");
		check(nodeEnable, 32'hA5A5FF00, "vector output");
	endtask : t_set_clear

	task t_route;
		vec = 32'hA5A5FF00;
		for (int n = 0; n < NODE_LOW_COUNT; n++)
			req(6'(n), 1'b1, 1'b1, vec[n] ? 3'h4 : 3'h2);
		req(6'h08, 1'b0, 1'b1, 3'h2);
		req(6'h08, 1'b1, 1'b0, 3'h1);
	endtask : t_route

	task t_high;
		@(posedge clk);
		highEnable <= 32'h00000100;
		req(6'h28, 1'b1, 1'b1, 3'h4);
		req(6'h29, 1'b1, 1'b1, 3'h2);
	endtask : t_high

	task t_refuse;
		apb(1'b0, 12'h0F4, 32'h0, 4'hF);
		check({rd[30:0], err}, 32'h1, "unmapped read");
		apb(1'b1, OFS_ROUTE_COUNT, 32'hFFFFFFFF, 4'hF);
		check(32'(err), 32'h1, "read-only write");
		apb(1'b0, OFS_ROUTE_COUNT, 32'h0, 4'hF);
		check(rd, 32'h00120011, "route counts");
		apb(1'b0, OFS_ROUTE_LAST, 32'h0, 4'hF);
		check(rd, 32'h00000029, "last route");
		apb(1'b0, 12'h109, 32'h0, 4'hF);
		check(32'(err), 32'h1, "misaligned read");
		apb(1'b0, OFS_NODE_EN_LOW_SET, 32'h0, 4'hF);
		check(rd, 32'hA5A5FF00, "vector kept");
	endtask : t_refuse

	// ----------------------------------------------------------------
	// Timeout and main sequence
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		reqValid = 1'b0;
		reqPhysTarget = 1'b0;
		reqAsyncPass = 1'b0;
		reqSrcNode = '0;
		highEnable = '0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_set_clear();
		t_route();
		t_high();
		t_refuse();
		end_sim();
	end

endmodule : physical_request_filter_low_bench

`default_nettype wire
